// >>> include/piu_pkg.sv
`default_nettype none
package piu_pkg;
	// ----------------------------------------
	// Widths and source counts
	// ----------------------------------------
	localparam int NUM_SRC   = 44;
	localparam int IDX_W     = 6;
	localparam int MASK_W    = 12;
	localparam int ADDR_W    = 15;
	localparam int WORD_W    = 24;
	localparam int NUM_CHAN  = 4;
	localparam int NUM_LINE  = 8;
	localparam int NUM_EXT   = 32;
	localparam int SYNC_W    = 40;
	// ----------------------------------------
	// Scan order, index 0 ranks highest
	// ----------------------------------------
	localparam logic [5:0] IDX_OVF  = 6'h00;
	localparam logic [5:0] IDX_EXT0 = 6'h04;
	localparam logic [5:0] IDX_CH0  = 6'h24;
	localparam logic [5:0] IDX_SM   = 6'h28;
	localparam logic [5:0] IDX_RTC  = 6'h29;
	localparam logic [5:0] IDX_MAN  = 6'h2a;
	localparam logic [5:0] IDX_AP   = 6'h2b;
	// ----------------------------------------
	// Mask register bit positions
	// ----------------------------------------
	localparam int MB_RTC  = 8;
	localparam int MB_EXP  = 9;
	localparam int MB_ARI  = 10;
	localparam int MB_SM   = 11;
	localparam logic [11:0] MASK_RST = 12'h000;
	localparam logic [7:0]  MASK_HI  = 8'hf0;
	// ----------------------------------------
	// Condition codes (octal)
	// ----------------------------------------
	localparam logic [11:0] CODE_CHAN = 12'o0100;
	localparam logic [11:0] CODE_RTC  = 12'o0110;
	localparam logic [11:0] CODE_OVF  = 12'o0111;
	localparam logic [11:0] CODE_SM   = 12'o0115;
	localparam logic [11:0] CODE_MAN  = 12'o0116;
	localparam logic [11:0] CODE_AP   = 12'o0117;
	// ----------------------------------------
	// Low memory locations and write masks
	// ----------------------------------------
	localparam logic [14:0] RET_ADDR  = 15'o00004;
	localparam logic [14:0] VEC_ADDR  = 15'o00005;
	localparam logic [23:0] FULL_MASK = 24'hffffff;
	localparam logic [23:0] CODE_MASK = 24'h000fff;
	// ----------------------------------------
	// Entry sequence states, Gray coded
	// ----------------------------------------
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_RET  = 2'b01,
		SEQ_CODE = 2'b11
	} seq_e;
endpackage : piu_pkg
`default_nettype wire

// >>> src/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             arst_n,
	// Pins in, synchronised out
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinOut
);
	logic [WIDTH-1:0] stage1;

	// Two flops; only the second stage is read outside
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stage1 <= '0;
			pinOut <= '0;
		end else begin
			stage1 <= pinIn;
			pinOut <= stage1;
		end
	end
endmodule : pin_sync
`default_nettype wire

// >>> src/first_set.sv
`timescale 1ns/100ps
`default_nettype none
module first_set #(
	parameter int N  = 44,
	parameter int IW = 6
) (
	// Request vector, bit 0 ranks highest
	input  wire logic [N-1:0] req,
	// Winner
	output logic              found,
	output logic [IW-1:0]     idx
);
	// Walk down from bit N-1 so the lowest set bit wins
	always_comb begin
		found = 1'b0;
		idx   = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				idx   = IW'(i);
			end
		end
	end
endmodule : first_set
`default_nettype wire

// >>> src/prioritized_interrupt_unit.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RL1: Search/move 40, clock 41, manual 42, processor 43
// RL2: Sense ignores mask; sensing clears faults
// RL3: Absent channels sense active, mask stays zero
// RL4: Four events clear equipment interrupts
// RL5: Channel interrupts cleared only by two instructions and master clear
// RL6: 32 lines; lower line, lower channel win; code ranks by channel first, then by line
// RL7: Lower channel wins among channel interrupts
// RL8: Clock, arithmetic, search/move cleared four ways
// RL9: Mask-operand clear hits channel and internal interrupts, not equipment
// RL10: Program clears equipment before channel interrupt
// RL11: Manual, processor interrupts self-clear when taken
// RL12: Take needs mask, enable, cause, scan
// RL13: Take at fetch point, store P at 00004
// RL14: Code into low 12 bits of 00005
// RL15: Then fetch from address 00005
// RL16: Octal codes carry line and channel
// RL17: Internal codes run 0110 through 0117
// RL18: Twelve mask bits, fixed source layout
// RL19: Set/clear mask alter selected bits only
// RL20: Entry disables; enable lags one instruction
// RL21: Scanner returns to top after service
// RL22: Exactly one, highest, taken per fetch point
module prioritized_interrupt_unit (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// Pins from equipment and console
	input  wire logic [31:0] extIrq,
	input  wire logic [3:0]  chanPresent,
	input  wire logic        manualSwitch,
	input  wire logic        master_clear_button,
	input  wire logic        extClearButton,
	input  wire logic        intClearButton,
	// Internal condition events
	input  wire logic [3:0]  chanEvent,
	input  wire logic        rtcEvent,
	input  wire logic        ovfEvent,
	input  wire logic        divEvent,
	input  wire logic        expEvent,
	input  wire logic        bcdEvent,
	input  wire logic        smEvent,
	input  wire logic        apEvent,
	// Instruction strobes from the sequencer
	input  wire logic        fetch_next_cycle,
	input  wire logic [14:0] pAddr,
	input  wire logic        instrDone,
	input  wire logic        global_enable_instr,
	input  wire logic        disableInstr,
	input  wire logic        mask_bit_set_instr,
	input  wire logic        mask_bit_clear_instr,
	input  wire logic [11:0] maskOperand,
	input  wire logic        sense_interrupt_instr,
	input  wire logic [11:0] senseSel,
	input  wire logic        mask_operand_clear_instr,
	input  wire logic        channel_equipment_clear_instr,
	input  wire logic [3:0]  chanSel,
	input  wire logic        funcStrobe,
	input  wire logic        funcReselect,
	input  wire logic [1:0]  funcChan,
	input  wire logic [2:0]  funcLine,
	// Memory writes and vectoring
	output logic             memWe,
	output logic [14:0]      memAddr,
	output logic [23:0]      memData,
	output logic [23:0]      memMask,
	output logic             jumpReq,
	output logic [14:0]      jumpAddr,
	// Status
	output logic             irqTaken,
	output logic [11:0]      irqCode,
	output logic             senseValid,
	output logic [11:0]      senseResult,
	output logic [11:0]      maskOut,
	output logic             intEnabled
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [11:0]     mask;
		logic            gEn;
		logic            arm;
		logic            ovf, div, exp, bcd;
		logic            sm, rtc, man, ap;
		logic [3:0]      chanPend;
		logic [31:0]     equip;
		logic [31:0]     extPrev;
		logic            manPrev;
		piu_pkg::seq_e   fsm;
		logic [11:0]     code;
		logic            memWe;
		logic [14:0]     memAddr;
		logic [23:0]     memData;
		logic [23:0]     memMask;
		logic            jump;
		logic [14:0]     jumpAddr;
		logic            taken;
		logic            sValid;
		logic [11:0]     sRes;
	} state_s;

	state_s st;
	state_s next_st;

	logic [31:0] extS;
	logic [3:0]  presS;
	logic        manS, mcS, extClrS, intClrS;
	logic [43:0] req;
	logic [3:0]  chq;
	logic [31:0] exq;
	logic [11:0] validMask;
	logic        found;
	logic [5:0]  idx;
	logic        takeNow;
	logic        clrAri, clrExp, clrRtc, clrSm;
	logic [3:0]  clrCh;
	logic [31:0] clrEq;
	logic [31:0] funcHit;
	logic [3:0]  chanAct;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	pin_sync #(.WIDTH(piu_pkg::SYNC_W)) u_sync (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.pinIn   ({extIrq, chanPresent, manualSwitch,
		            master_clear_button, extClearButton, intClearButton}),
		.pinOut  ({extS, presS, manS, mcS, extClrS, intClrS})
	);

	// ----------------------------------------
	// Priority scan
	// ----------------------------------------
	// Absent channels cannot keep a mask bit past the next edge
	assign validMask = {piu_pkg::MASK_HI, presS}; // see RL3 see RL18

	// Each source qualified by its mask bit; manual, processor unmasked
	always_comb begin
		for (int c = 0; c < piu_pkg::NUM_CHAN; c++) begin
			exq[c*8 +: 8] = st.equip[c*8 +: 8] & {8{st.mask[c] & presS[c]}}; // see RL6
			chq[c]        = st.chanPend[c] & st.mask[c] & presS[c]; // see RL7
		end
	end

	// Bit order is the scan order from the top of the list
	assign req = {st.ap, st.man,
	              st.rtc & st.mask[piu_pkg::MB_RTC],
	              st.sm & st.mask[piu_pkg::MB_SM],
	              chq, exq,
	              st.bcd & st.mask[piu_pkg::MB_EXP],
	              st.exp & st.mask[piu_pkg::MB_EXP],
	              st.div & st.mask[piu_pkg::MB_ARI],
	              st.ovf & st.mask[piu_pkg::MB_ARI]}; // see RL1 see RL12

	first_set #(.N(piu_pkg::NUM_SRC), .IW(piu_pkg::IDX_W)) u_scan (
		.req   (req),
		.found (found),
		.idx   (idx)
	); // see RL22

	// Recognition only at the fetch point, with the system enabled
	assign takeNow = fetch_next_cycle && found && st.gEn
	                 && (st.fsm == piu_pkg::SEQ_IDLE); // see RL12 see RL13

	// Octal code of a scan index
	function automatic logic [11:0] codeOf(input logic [5:0] i);
		logic [5:0] e;
		e = i - piu_pkg::IDX_EXT0;
		if (i < piu_pkg::IDX_EXT0)
			codeOf = piu_pkg::CODE_OVF + {10'h000, i[1:0]}; // see RL17
		else if (i < piu_pkg::IDX_CH0)
			codeOf = {6'h00, e[2:0], 1'b0, e[4:3]}; // see RL16
		else if (i < piu_pkg::IDX_SM)
			codeOf = piu_pkg::CODE_CHAN | {10'h000, i[1:0]}; // see RL16
		else if (i == piu_pkg::IDX_SM)
			codeOf = piu_pkg::CODE_SM;
		else if (i == piu_pkg::IDX_RTC)
			codeOf = piu_pkg::CODE_RTC;
		else if (i == piu_pkg::IDX_MAN)
			codeOf = piu_pkg::CODE_MAN;
		else
			codeOf = piu_pkg::CODE_AP; // see RL17
	endfunction : codeOf

	// ----------------------------------------
	// Clear terms
	// ----------------------------------------
	// Internal clears come from sense, mask-operand clear or buttons
	assign clrAri = mcS | intClrS
	                | (mask_operand_clear_instr & st.mask[piu_pkg::MB_ARI])
	                | (sense_interrupt_instr & senseSel[piu_pkg::MB_ARI]); // see RL8
	assign clrExp = mcS | intClrS
	                | (mask_operand_clear_instr & st.mask[piu_pkg::MB_EXP])
	                | (sense_interrupt_instr & senseSel[piu_pkg::MB_EXP]); // see RL2
	assign clrRtc = mcS | intClrS
	                | (mask_operand_clear_instr & st.mask[piu_pkg::MB_RTC])
	                | (sense_interrupt_instr & senseSel[piu_pkg::MB_RTC]); // see RL8
	assign clrSm  = mcS | intClrS
	                | (mask_operand_clear_instr & st.mask[piu_pkg::MB_SM])
	                | (sense_interrupt_instr & senseSel[piu_pkg::MB_SM]); // see RL8

	// Channel interrupts: mask-operand clear uses the mask as selection
	assign clrCh = {4{mcS}}
	               | ({4{mask_operand_clear_instr}} & st.mask[3:0]) // see RL9
	               | ({4{channel_equipment_clear_instr}} & chanSel); // see RL5

	// Function code addresses one equipment line
	always_comb begin
		funcHit = '0;
		funcHit[{funcChan, funcLine}] = funcStrobe & funcReselect;
	end

	// Equipment lines; mask-operand clear leaves these alone
	assign clrEq = {32{mcS | extClrS}} | funcHit
	               | ({32{channel_equipment_clear_instr}}
	                  & {{8{chanSel[3]}}, {8{chanSel[2]}},
	                     {8{chanSel[1]}}, {8{chanSel[0]}}}); // see RL4 see RL10

	// Sense view per channel; missing channels always look active
	always_comb begin
		for (int c = 0; c < piu_pkg::NUM_CHAN; c++)
			chanAct[c] = presS[c] ? (st.chanPend[c] | (|st.equip[c*8 +: 8]))
			                      : 1'b1; // see RL3
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	// Events always beat a clear in the same cycle
	always_comb begin
		next_st        = st;
		next_st.memWe  = 1'b0;
		next_st.jump   = 1'b0;
		next_st.taken  = 1'b0;
		next_st.sValid = 1'b0;

		// Mask update, then strip bits that may not be held
		if (mask_bit_set_instr)
			next_st.mask = st.mask | maskOperand; // see RL19
		if (mask_bit_clear_instr)
			next_st.mask = next_st.mask & ~maskOperand; // see RL19
		next_st.mask = next_st.mask & validMask; // see RL3

		// Pending conditions
		next_st.ovf = (st.ovf & ~clrAri) | ovfEvent;
		next_st.div = (st.div & ~clrAri) | divEvent;
		next_st.exp = (st.exp & ~clrExp) | expEvent;
		next_st.bcd = (st.bcd & ~clrExp) | bcdEvent;
		next_st.rtc = (st.rtc & ~clrRtc) | rtcEvent;
		next_st.sm  = (st.sm & ~clrSm) | smEvent;
		next_st.chanPend = (st.chanPend & ~clrCh) | chanEvent; // see RL5
		next_st.extPrev  = extS;
		next_st.equip    = (st.equip & ~clrEq) | (extS & ~st.extPrev);
		next_st.manPrev  = manS;
		next_st.man = (st.man & ~mcS) | (manS & ~st.manPrev);
		next_st.ap  = (st.ap & ~mcS) | apEvent;

		// Sense reports pending state whatever the mask holds
		if (sense_interrupt_instr) begin
			next_st.sValid = 1'b1;
			next_st.sRes   = senseSel & {st.sm, st.ovf | st.div,
			                             st.exp | st.bcd, st.rtc,
			                             4'h0, chanAct}; // see RL2
		end

		// Enable takes hold only after one more instruction
		if (instrDone && st.arm) begin
			next_st.gEn = 1'b1;
			next_st.arm = 1'b0;
		end
		if (global_enable_instr)
			next_st.arm = 1'b1; // see RL20
		if (disableInstr || mcS) begin
			next_st.gEn = 1'b0;
			next_st.arm = 1'b0;
		end

		// Entry sequence: return address, code, then vector
		case (st.fsm)
			piu_pkg::SEQ_IDLE: begin
				if (takeNow) begin
					next_st.taken   = 1'b1;
					next_st.gEn     = 1'b0; // see RL20
					next_st.arm     = 1'b0;
					next_st.code    = codeOf(idx);
					next_st.memWe   = 1'b1;
					next_st.memAddr = piu_pkg::RET_ADDR; // see RL13
					next_st.memData = {9'h000, pAddr};
					next_st.memMask = piu_pkg::FULL_MASK;
					next_st.fsm     = piu_pkg::SEQ_RET;
					// Self-clearing sources; set still wins
					if (idx == piu_pkg::IDX_MAN)
						next_st.man = manS & ~st.manPrev; // see RL11
					if (idx == piu_pkg::IDX_AP)
						next_st.ap = apEvent; // see RL11
				end
			end
			piu_pkg::SEQ_RET: begin
				next_st.memWe   = 1'b1;
				next_st.memAddr = piu_pkg::VEC_ADDR;
				next_st.memData = {12'h000, st.code};
				next_st.memMask = piu_pkg::CODE_MASK; // see RL14
				next_st.fsm     = piu_pkg::SEQ_CODE;
			end
			piu_pkg::SEQ_CODE: begin
				next_st.jump     = 1'b1;
				next_st.jumpAddr = piu_pkg::VEC_ADDR; // see RL15
				next_st.fsm      = piu_pkg::SEQ_IDLE; // see RL21
			end
			default: next_st.fsm = piu_pkg::SEQ_IDLE;
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st      <= '0;
			st.mask <= piu_pkg::MASK_RST;
			st.fsm  <= piu_pkg::SEQ_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flops
	assign memWe       = st.memWe;
	assign memAddr     = st.memAddr;
	assign memData     = st.memData;
	assign memMask     = st.memMask;
	assign jumpReq     = st.jump;
	assign jumpAddr    = st.jumpAddr;
	assign irqTaken    = st.taken;
	assign irqCode     = st.code;
	assign senseValid  = st.sValid;
	assign senseResult = st.sRes;
	assign maskOut     = st.mask;
	assign intEnabled  = st.gEn;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_ret_store: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL13
		takeNow |=> memWe && memAddr == piu_pkg::RET_ADDR
		            && memData[14:0] == $past(pAddr))
		else $error("return address not stored");
	chk_code_store: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL14
		takeNow |=> ##1 memWe && memAddr == piu_pkg::VEC_ADDR
		            && memMask == piu_pkg::CODE_MASK && memData[11:0] == irqCode)
		else $error("code not stored");
	chk_vector_jump: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL15
		takeNow |=> ##2 jumpReq && jumpAddr == piu_pkg::VEC_ADDR)
		else $error("no vector jump");
	chk_entry_off: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL20
		takeNow |=> !intEnabled [*3])
		else $error("enable survives entry");
	chk_enable_lag: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL20
		global_enable_instr && !intEnabled |=> !intEnabled)
		else $error("enable took effect early");
	chk_absent_mask: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL3
		$stable(presS) |-> (maskOut[3:0] & ~presS) == 4'h0)
		else $error("absent channel mask set");
	chk_absent_sense: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL3
		sense_interrupt_instr |=> senseValid
		&& ((~$past(presS) & $past(senseSel[3:0]) & ~senseResult[3:0]) == 4'h0))
		else $error("absent channel sensed idle");
	chk_sense_clear: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL2
		sense_interrupt_instr && senseSel[piu_pkg::MB_ARI] && !ovfEvent |=> !st.ovf)
		else $error("sensed fault not cleared");
	chk_manual_clear: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL11
		takeNow && idx == piu_pkg::IDX_MAN && !(manS && !st.manPrev) |=> !st.man)
		else $error("manual not self-cleared");
	chk_rtc_code: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL17
		takeNow && idx == piu_pkg::IDX_RTC |=> irqTaken && irqCode == piu_pkg::CODE_RTC)
		else $error("wrong clock code");
	chk_top_line: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL6
		takeNow && req[piu_pkg::IDX_EXT0] && req[3:0] == 4'h0 |=> irqCode == 12'h000)
		else $error("line 0 channel 0 lost");
endmodule : prioritized_interrupt_unit
`default_nettype wire

// >>> tb/seq_model.sv
`timescale 1ns/100ps
`default_nettype none
module seq_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// Writes and vectoring from the interrupt unit
	input  wire logic        memWe,
	input  wire logic [14:0] memAddr,
	input  wire logic [23:0] memData,
	input  wire logic [23:0] memMask,
	input  wire logic        jumpReq,
	input  wire logic [14:0] jumpAddr,
	// Sequencer strobes
	output logic             fetch_next_cycle,
	output logic [14:0]      pAddr,
	output logic             instrDone,
	// Low memory words and P seen at the last fetch point
	output logic [23:0]      retWord,
	output logic [23:0]      codeWord,
	output logic [14:0]      lastP
);
	// ----------------------------------------
	// Sequencer and low memory
	// ----------------------------------------
	logic [1:0] phase;

	// Four-cycle instructions; the code word starts non-zero so a write
	// that ignores its write mask shows up in the upper bits
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase            <= 2'h0;
			fetch_next_cycle <= 1'b0;
			instrDone        <= 1'b0;
			pAddr            <= 15'h0100;
			lastP            <= 15'h0000;
			retWord          <= 24'h000000;
			codeWord         <= 24'ha5a000;
		end else begin
			phase            <= phase + 2'h1;
			fetch_next_cycle <= (phase == 2'h3);
			instrDone        <= (phase == 2'h1);
			if (fetch_next_cycle) begin
				lastP <= pAddr;
			end
			if (jumpReq) begin
				pAddr <= jumpAddr;
			end else if (fetch_next_cycle) begin
				pAddr <= pAddr + 15'h0001;
			end
			if (memWe && memAddr == 15'h0004) begin
				retWord <= (retWord & ~memMask) | (memData & memMask);
			end
			if (memWe && memAddr == 15'h0005) begin
				codeWord <= (codeWord & ~memMask) | (memData & memMask);
			end
		end
	end
endmodule : seq_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        sys_clk = 1'b0;
	logic        arst_n;
	logic [15:0] stb;
	logic [11:0] op;
	logic [31:0] extIrq;
	logic [3:0]  chanPresent;
	logic [3:0]  btn;
	logic        fetch_next_cycle, instrDone, memWe, jumpReq, irqTaken, senseValid, intEnabled;
	logic [14:0] pAddr, memAddr, jumpAddr, lastP;
	logic [23:0] memData, memMask, retWord, codeWord;
	logic [11:0] irqCode, senseResult, maskOut;
	int          num_errors;
	int          n_tests;

	// 20 MHz clock
	always #25 sys_clk = ~sys_clk;

	// Strobe map: 0 en, 1 dis, 2 set, 3 clr, 4 sense, 5 opclr, 6 eqclr, 7 func,
	// 8 rtc, 9 ovf, 10 sm, 11 ap, 12 div, 13 exp, 14 bcd, 15 channel events
	prioritized_interrupt_unit DUT (.sys_clk(sys_clk), .arst_n(arst_n), .extIrq(extIrq),
		.chanPresent(chanPresent), .manualSwitch(btn[0]), .master_clear_button(btn[1]),
		.extClearButton(btn[2]), .intClearButton(btn[3]),
		.chanEvent(stb[15] ? op[3:0] : 4'h0),
		.rtcEvent(stb[8]), .ovfEvent(stb[9]), .divEvent(stb[12]), .expEvent(stb[13]),
		.bcdEvent(stb[14]), .smEvent(stb[10]), .apEvent(stb[11]),
		.fetch_next_cycle(fetch_next_cycle), .pAddr(pAddr), .instrDone(instrDone),
		.global_enable_instr(stb[0]), .disableInstr(stb[1]), .mask_bit_set_instr(stb[2]),
		.mask_bit_clear_instr(stb[3]), .maskOperand(op), .sense_interrupt_instr(stb[4]),
		.senseSel(op), .mask_operand_clear_instr(stb[5]), .channel_equipment_clear_instr(stb[6]),
		.chanSel(op[3:0]), .funcStrobe(stb[7]), .funcReselect(op[11]), .funcChan(op[4:3]),
		.funcLine(op[2:0]), .memWe(memWe), .memAddr(memAddr), .memData(memData),
		.memMask(memMask), .jumpReq(jumpReq), .jumpAddr(jumpAddr), .irqTaken(irqTaken),
		.irqCode(irqCode), .senseValid(senseValid), .senseResult(senseResult),
		.maskOut(maskOut), .intEnabled(intEnabled));

	// Far side: instruction sequencer and low memory
	seq_model partner (.sys_clk(sys_clk), .arst_n(arst_n), .memWe(memWe), .memAddr(memAddr),
		.memData(memData), .memMask(memMask), .jumpReq(jumpReq), .jumpAddr(jumpAddr),
		.fetch_next_cycle(fetch_next_cycle), .pAddr(pAddr), .instrDone(instrDone),
		.retWord(retWord), .codeWord(codeWord), .lastP(lastP));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task results;
		$display("Checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	task chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask : chk

	// One-cycle strobe with its operand; returns just after the taking edge
	task strobe(input int i, input logic [11:0] v);
		@(posedge sys_clk);
		op     <= v;
		stb[i] <= 1'b1;
		@(posedge sys_clk);
		stb[i] <= 1'b0;
		#1;
	endtask : strobe

	// Enable, then wait for one entry (or none) and judge the whole entry sequence
	task enter(input logic [11:0] code, input logic none);
		logic hit;
		hit = 1'b0;
		strobe(0, 12'h000);
		chk(24'(intEnabled), 24'h0);
		for (int k = 0; k < 40 && !hit; k++) begin
			@(posedge sys_clk);
			#1;
			hit = (irqTaken === 1'b1);
		end
		chk(24'(hit), 24'(!none));
		if (!hit && !none) begin
			results();
		end
		if (hit) begin
			chk(24'(irqCode), 24'(code));
			chk(24'(intEnabled), 24'h0);
			@(posedge sys_clk);
			@(posedge sys_clk);
			#1;
			chk({8'h0, jumpReq, jumpAddr}, 24'h008005);
			chk(retWord, {9'h000, lastP});
			chk(codeWord, {12'ha5a, code});
		end else begin
			strobe(1, 12'h000);
		end
	endtask : enter

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		arst_n = 1'b0;
		stb = 16'h0000;
		op = 12'h000;
		extIrq = 32'h00000000;
		chanPresent = 4'h7;
		btn = 4'h0;
		num_errors = 0;
		n_tests = 0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		#1;
		chk(24'(maskOut), 24'h000);
		chk(24'(intEnabled), 24'h0);
		// Channel-present pins need two edges through the synchroniser
		repeat (2) @(posedge sys_clk);
		strobe(2, 12'hfff);
		chk(24'(maskOut), 24'h000f07);
		strobe(3, 12'h500);
		chk(24'(maskOut), 24'h000a07);
		// Fault sensed while its mask bit is clear, then gone
		strobe(9, 12'h000);
		strobe(4, 12'hfff);
		chk({11'h0, senseValid, senseResult}, 24'h001408);
		strobe(4, 12'hfff);
		chk(24'(senseResult), 24'h000008);
		// Internal sources: rtc masked out at first
		strobe(10, 12'h000);
		strobe(8, 12'h000);
		strobe(11, 12'h000);
		enter(12'h04d, 1'b0);
		strobe(4, 12'h800);
		chk(24'(senseResult), 24'h000800);
		enter(12'h04f, 1'b0);
		strobe(2, 12'h100);
		enter(12'h048, 1'b0);
		strobe(4, 12'h100);
		enter(12'h000, 1'b1);
		// Equipment lines: ch0 line 5 and ch1 line 3
		@(posedge sys_clk);
		extIrq <= 32'h00000820;
		enter(12'h028, 1'b0);
		strobe(7, 12'h805);
		enter(12'h019, 1'b0);
		strobe(6, 12'h002);
		// Channel events on ch1 and ch2
		strobe(15, 12'h006);
		enter(12'h041, 1'b0);
		strobe(6, 12'h002);
		enter(12'h042, 1'b0);
		// Mask-operand clear keeps the equipment latch of ch2
		@(posedge sys_clk);
		extIrq <= 32'h00010000;
		strobe(5, 12'h000);
		enter(12'h002, 1'b0);
		strobe(7, 12'h810);
		enter(12'h000, 1'b1);
		// BCD fault taken, divide fault left pending under a clear mask bit
		strobe(14, 12'h000);
		strobe(12, 12'h000);
		enter(12'h04c, 1'b0);
		strobe(4, 12'h200);
		chk(24'(senseResult), 24'h000200);
		// Console manual switch, unmasked and self-clearing
		@(posedge sys_clk);
		btn <= 4'h1;
		enter(12'h04e, 1'b0);
		// Master clear drops a new equipment line and the divide fault
		@(posedge sys_clk);
		extIrq <= 32'h00000001;
		btn    <= 4'h2;
		repeat (6) @(posedge sys_clk);
		btn    <= 4'h0;
		repeat (3) @(posedge sys_clk);
		strobe(4, 12'h401);
		chk(24'(senseResult), 24'h000000);
		enter(12'h000, 1'b1);
		results();
	end
endmodule : tb
`default_nettype wire
